// ### verilog/ctm_regs.vh
// Purpose: register map, field positions and reset values of the compact timer
// Assumes: apb byte addresses, one aligned word per register
// Notes:   holding-buffer ordering is software's job
`ifndef CTM_REGS_VH
`define CTM_REGS_VH
// ==========================================================================
// register offsets
`define CTM_OFS_CTRL0     12'h000
`define CTM_OFS_CTRL1     12'h004
`define CTM_OFS_CNT_LO    12'h008
`define CTM_OFS_CNT_HI    12'h00c
`define CTM_OFS_CMP_LO    12'h010
`define CTM_OFS_CMP_HI    12'h014
`define CTM_OFS_FLAGS     12'h018
// ==========================================================================
// reset values
`define CTM_CTRL0_RST     8'h00
`define CTM_CTRL1_RST     8'h00
// ==========================================================================
// control zero fields
`define CTM_C0_PAUSE      7
`define CTM_C0_CKS_HI     6
`define CTM_C0_CKS_LO     4
`define CTM_C0_ON         3
`define CTM_C0_RP_HI      2
`define CTM_C0_RP_LO      0
// control one fields
`define CTM_C1_MODE_HI    7
`define CTM_C1_MODE_LO    6
`define CTM_C1_IO_HI      5
`define CTM_C1_IO_LO      4
`define CTM_C1_OC         3
`define CTM_C1_POL        2
`define CTM_C1_DPX        1
`define CTM_C1_CCLR       0
// ==========================================================================
// modes, pin actions, clock selects
`define CTM_MODE_CMP      2'h0
`define CTM_MODE_PWM      2'h2
`define CTM_MODE_TMR      2'h3
`define CTM_IO_NONE       2'h0
`define CTM_IO_LOW        2'h1
`define CTM_IO_HIGH       2'h2
`define CTM_IO_TOG        2'h3
`define CTM_CK_SYS4       3'h0
`define CTM_CK_SYS        3'h1
`define CTM_CK_H16        3'h2
`define CTM_CK_H64        3'h3
`define CTM_CK_SUB0       3'h4
`define CTM_CK_SUB1       3'h5
`define CTM_CNT_MAX       10'h3ff
`define CTM_PRE_W         6
`endif

// ### verilog/ctm_timer.v
// Purpose: compact 10-bit count-up timer with compare, pwm and timer modes
// Assumes: system and high clock ticks are derived from pclk; subsidiary
//          clock arrives on a pin and is synchronised
// Notes:   flags register is write-one-to-clear, set beats clear
//
// Operation
// - ten-bit counter advances on the selected tick while on and not paused
// - comparator p checks counter bits 9..7, comparator a all ten bits
// - software cannot write the counter; of its own writes only on rising edge clears it
// - pause holds the counter; releasing pause resumes from that value
// - clock select picks sys/4, sys, high/16, high/64, subsidiary, reserved
// - off stops and keeps the count; off-to-on resets it to zero
// - off-to-on returns the pin to its initial level in compare and pwm
// - period field gives field times 128 ticks; zero means 1024
// - clear-select 0 clears on p match; overflow only when field is zero
// - clear-select 1 clears on comparator a match instead
// - pwm ignores clear-select; swap bit picks the clearing comparator
// - mode field: 00 compare, 01 undefined, 10 pwm, 11 timer
// - compare mode a match: no change, low, high or toggle the pin
// - pwm pin action: inactive, active, waveform, undefined
// - output control sets initial level or pwm active level
// - polarity bit inverts the pin; no effect in timer mode
// - swap 0: period field is period, compare is duty; 1 swapped
// - timer mode leaves the pin undriven by timer state
// - counter clears by overflow or match raise an interrupt request; overflow sets no flag in pwm with period field zero or with clear-select 1
// - counter readable as read-only pair; compare value read-write pair
// - compare low write goes to buffer; high write commits both bytes
// - high byte read latches low byte into buffer for later low read
// - clear-select 1 with compare zero overflows at 3ff, no a or p flag
// - pwm duty not below period keeps the output active all period
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "ctm_regs.vh"
module ctm_timer (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // clock source pin
  input  wire        subsidiary_clock,
  // timer outputs
  output reg         timer_output_pin,
  output reg         timer_output_pin_inverted,
  output reg         timer_output_enable_n,
  output reg         compare_a_flag,
  output reg         compare_p_flag
);
  // ========================================================================
  // registers
  reg  [7:0]  ctrl0_r;
  reg  [7:0]  ctrl1_r;
  reg  [9:0]  cmp_r;
  reg  [7:0]  hold_r;
  reg  [9:0]  cnt_r;
  reg  [9:0]  cnt_nxt;
  reg  [`CTM_PRE_W-1:0] pre_r;
  reg  [2:0]  sub_sync_r;
  reg         on_d_r;
  reg         sub_lvl_r;
  reg         sub_lvl_d_r;
  reg         pin_r;
  reg         pin_nxt;
  reg         tick;
  reg         hit_a;
  reg         hit_p;
  reg         clr;
  reg         set_a;
  reg         set_p;
  reg         pwm_lvl;

  wire        pause        = ctrl0_r[`CTM_C0_PAUSE];
  wire [2:0]  cks          = ctrl0_r[`CTM_C0_CKS_HI:`CTM_C0_CKS_LO];
  wire        on_bit       = ctrl0_r[`CTM_C0_ON];
  wire [2:0]  rp           = ctrl0_r[`CTM_C0_RP_HI:`CTM_C0_RP_LO];
  wire [1:0]  mode         = ctrl1_r[`CTM_C1_MODE_HI:`CTM_C1_MODE_LO];
  wire [1:0]  io           = ctrl1_r[`CTM_C1_IO_HI:`CTM_C1_IO_LO];
  wire        oc           = ctrl1_r[`CTM_C1_OC];
  wire        pol          = ctrl1_r[`CTM_C1_POL];
  wire        dpx          = ctrl1_r[`CTM_C1_DPX];
  wire        cclr         = ctrl1_r[`CTM_C1_CCLR];
  wire        on_rise      = on_bit & ~on_d_r;
  wire        acc          = psel & penable;
  wire        wr           = acc & pwrite;
  wire        sub_edge     = sub_lvl_r & ~sub_lvl_d_r;
  // only the first access edge clears, like every other register write
  wire        w1c          = wr & ~pready & (paddr == `CTM_OFS_FLAGS);

  // count sits at 3ff on a tick, so the next step wraps
  function at_top;
    input       t;
    input [9:0] c;
    begin
      at_top = t & (c == `CTM_CNT_MAX);
    end
  endfunction

  // period and duty in ticks; zero period field means the full 1024
  function [10:0] p_ticks;
    input [2:0] f;
    begin
      p_ticks = (f == 3'h0) ? 11'h400 : {1'b0, f, 7'h00};
    end
  endfunction

  // address decode shared by read and write paths
  function known;
    input [11:0] a;
    begin
      known = (a == `CTM_OFS_CTRL0) | (a == `CTM_OFS_CTRL1) |
              (a == `CTM_OFS_CNT_LO) | (a == `CTM_OFS_CNT_HI) |
              (a == `CTM_OFS_CMP_LO) | (a == `CTM_OFS_CMP_HI) |
              (a == `CTM_OFS_FLAGS);
    end
  endfunction

  // ========================================================================
  // subsidiary pin: level taken once stages two and three agree, so a
  // single-cycle glitch on the pin never makes a tick
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sub_lvl_r   <= 1'b0;
      sub_lvl_d_r <= 1'b0;
    end else begin
      if (sub_sync_r[1] == sub_sync_r[2])
        sub_lvl_r <= sub_sync_r[2];
      sub_lvl_d_r <= sub_lvl_r;
    end
  end

  // ========================================================================
  // tick selection
  always @* begin
    case (cks)
      `CTM_CK_SYS4: tick = (pre_r[1:0] == 2'h3);
      `CTM_CK_SYS:  tick = 1'b1;
      `CTM_CK_H16:  tick = (pre_r[3:0] == 4'hf);
      `CTM_CK_H64:  tick = (pre_r == 6'h3f);
      `CTM_CK_SUB0: tick = sub_edge;
      `CTM_CK_SUB1: tick = sub_edge;
      default:      tick = 1'b0;
    endcase
  end

  // ========================================================================
  // comparators and clear choice
  always @* begin
    hit_a = tick & (cnt_r == cmp_r);
    hit_p = tick & (rp != 3'h0) & (cnt_r[9:7] == rp);
    clr   = 1'b0;
    set_a = 1'b0;
    set_p = 1'b0;
    if (mode == `CTM_MODE_PWM) begin
      // in pwm a value of zero clears at the full 1024 count
      if (dpx)
        clr = (cmp_r == 10'h000) ? at_top(tick, cnt_r) : hit_a;
      else
        clr = (rp == 3'h0) ? at_top(tick, cnt_r) : hit_p;
      set_a = hit_a;
      set_p = hit_p;
    end else if (cclr) begin
      // a zero compare value must not clear every tick; it wraps at 3ff
      clr   = (cmp_r == 10'h000) ? at_top(tick, cnt_r) : hit_a;
      set_a = hit_a & (cmp_r != 10'h000);
    end else begin
      clr   = hit_p | ((rp == 3'h0) & at_top(tick, cnt_r));
      set_a = hit_a;
      set_p = hit_p | ((rp == 3'h0) & at_top(tick, cnt_r));
    end
  end

  // ========================================================================
  // counter next value
  always @* begin
    cnt_nxt = cnt_r;
    if (on_rise)
      cnt_nxt = 10'h000;
    else if (on_bit & ~pause & tick) begin
      if (clr)
        cnt_nxt = 10'h000;
      else
        cnt_nxt = cnt_r + 10'h001;
    end
  end

  // ========================================================================
  // pwm level: active while count below duty, full when duty covers period
  always @* begin
    if (dpx)
      pwm_lvl = ({1'b0, cnt_r} < p_ticks(rp)) |
                (p_ticks(rp) >= ((cmp_r == 10'h000) ? 11'h400
                                 : {1'b0, cmp_r}));
    else
      pwm_lvl = ({1'b0, cnt_r} < {1'b0, cmp_r}) |
                ({1'b0, cmp_r} >= p_ticks(rp));
  end

  // ========================================================================
  // pin next value
  always @* begin
    pin_nxt = pin_r;
    if (on_rise)
      pin_nxt = (mode == `CTM_MODE_PWM) ? ~oc : oc;
    else if (mode == `CTM_MODE_CMP) begin
      if (set_a & on_bit & ~pause) begin
        case (io)
          `CTM_IO_LOW:  pin_nxt = 1'b0;
          `CTM_IO_HIGH: pin_nxt = 1'b1;
          `CTM_IO_TOG:  pin_nxt = ~pin_r;
          default:      pin_nxt = pin_r;
        endcase
      end
    end else if (mode == `CTM_MODE_PWM) begin
      // active level follows output control
      case (io)
        `CTM_IO_NONE: pin_nxt = ~oc;
        `CTM_IO_LOW:  pin_nxt = oc;
        `CTM_IO_HIGH: pin_nxt = on_bit ? (pwm_lvl ? oc : ~oc) : pin_r;
        default:      pin_nxt = pin_r;
      endcase
    end
  end

  // ========================================================================
  // timer state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r      <= 10'h000;
      pre_r      <= {`CTM_PRE_W{1'b0}};
      sub_sync_r <= 3'h0;
      on_d_r     <= 1'b0;
      pin_r      <= 1'b0;
    end else begin
      cnt_r      <= cnt_nxt;
      pre_r      <= pre_r + {{(`CTM_PRE_W-1){1'b0}}, 1'b1};
      // first stage feeds only the second stage
      sub_sync_r <= {sub_sync_r[1:0], subsidiary_clock};
      on_d_r     <= on_bit;
      pin_r      <= pin_nxt;
    end
  end

  // ========================================================================
  // outputs, straight from flip-flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_output_pin          <= 1'b0;
      timer_output_pin_inverted <= 1'b1;
      timer_output_enable_n     <= 1'b1;
      compare_a_flag            <= 1'b0;
      compare_p_flag            <= 1'b0;
    end else begin
      timer_output_pin          <= pin_nxt ^ pol;
      timer_output_pin_inverted <= ~(pin_nxt ^ pol);
      // timer mode and the undefined mode release the pin
      timer_output_enable_n     <= ~((mode == `CTM_MODE_CMP) |
                                     (mode == `CTM_MODE_PWM));
      // set wins over a same-cycle clear
      compare_a_flag <= (set_a & on_bit & ~pause) |
                        (compare_a_flag & ~(w1c & pwdata[0]));
      compare_p_flag <= (set_p & on_bit & ~pause) |
                        (compare_p_flag & ~(w1c & pwdata[1]));
    end
  end

  // ========================================================================
  // apb registers; the buffer pairs accesses, so order matters to software
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_r <= `CTM_CTRL0_RST;
      ctrl1_r <= `CTM_CTRL1_RST;
      cmp_r   <= 10'h000;
      hold_r  <= 8'h00;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // one wait state: answer in the cycle after the first access cycle
      pready  <= acc & ~pready;
      pslverr <= acc & ~pready & ~known(paddr);
      prdata  <= 32'h0000_0000;
      if (acc & ~pready) begin
        if (pwrite) begin
          case (paddr)
            `CTM_OFS_CTRL0:  ctrl0_r <= pwdata[7:0];
            `CTM_OFS_CTRL1:  ctrl1_r <= pwdata[7:0];
            `CTM_OFS_CMP_LO: hold_r  <= pwdata[7:0];
            `CTM_OFS_CMP_HI: cmp_r   <= {pwdata[1:0], hold_r};
            default:         hold_r  <= hold_r;
          endcase
        end else begin
          case (paddr)
            `CTM_OFS_CTRL0:  prdata <= {24'h000000, ctrl0_r};
            `CTM_OFS_CTRL1:  prdata <= {24'h000000, ctrl1_r};
            `CTM_OFS_CNT_LO: prdata <= {24'h000000, hold_r};
            `CTM_OFS_CNT_HI: begin
              prdata <= {30'h0, cnt_r[9:8]};
              hold_r <= cnt_r[7:0];
            end
            `CTM_OFS_CMP_LO: prdata <= {24'h000000, hold_r};
            `CTM_OFS_CMP_HI: begin
              prdata <= {30'h0, cmp_r[9:8]};
              hold_r <= cmp_r[7:0];
            end
            `CTM_OFS_FLAGS:  prdata <= {30'h0, compare_p_flag,
                                        compare_a_flag};
            default:         prdata <= 32'h0000_0000;
          endcase
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### test/ctm_checker.sv
// Purpose: port-level checker for the compact timer
// Assumes: apb writes land on the first access edge
// Notes:   shadows the control bits from bus writes
`timescale 1ns/1ns
`default_nettype none
`include "ctm_regs.vh"
module ctm_checker (
  // clock, reset and apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins and the compare a flag
  input wire logic        timer_output_pin,
  input wire logic        timer_output_pin_inverted,
  input wire logic        timer_output_enable_n,
  input wire logic        compare_a_flag
);
  // ====
  // shadow state
  logic       on_r;
  logic [1:0] mode_r;
  logic       lvl_r;
  logic       clr_r;
  wire        wr = psel && penable && pwrite && !pready;
  wire        clr = wr && paddr == `CTM_OFS_FLAGS && pwdata[0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {on_r, mode_r, lvl_r, clr_r} <= 5'h00;
    end else begin
      clr_r <= clr;
      if (wr && paddr == `CTM_OFS_CTRL0)
        on_r <= pwdata[3];
      // pwm starts at the inactive level, compare at the chosen one
      if (wr && paddr == `CTM_OFS_CTRL1) begin
        mode_r <= pwdata[7:6];
        lvl_r  <= pwdata[3] ^ pwdata[2] ^ (pwdata[7:6] == `CTM_MODE_PWM);
      end
    end
  end
  // ====
  // properties
  property p_inv; timer_output_pin_inverted == !timer_output_pin; endproperty
  a_inv: assert property (p_inv) else $error("pin pair not inverse");
  property p_ready; psel && penable && !pready |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no answer");
  property p_once; pready |=> !pready; endproperty
  a_once: assert property (p_once) else $error("ready too long");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("bad error answer");
  property p_drive; !mode_r[0] |-> ##1 !timer_output_enable_n; endproperty
  a_drive: assert property (p_drive) else $error("pin not driven");
  property p_release; mode_r[0] |-> ##1 timer_output_enable_n; endproperty
  a_release: assert property (p_release) else $error("pin driven");
  property p_onrise; wr && paddr == `CTM_OFS_CTRL0 && pwdata[3] && !on_r &&
    !mode_r[0] |-> ##[1:3] timer_output_pin == lvl_r; endproperty
  a_onrise: assert property (p_onrise) else $error("bad start level");
  property p_flag; compare_a_flag && !clr && !clr_r |=> compare_a_flag;
  endproperty
  a_flag: assert property (p_flag) else $error("flag lost");
endmodule
bind ctm_timer ctm_checker u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer_output_pin(timer_output_pin),
  .timer_output_pin_inverted(timer_output_pin_inverted),
  .timer_output_enable_n(timer_output_enable_n),
  .compare_a_flag(compare_a_flag));
`default_nettype wire

// ### test/compact_timer_10bit_tb.sv
// Purpose: self-checking bench for the compact timer
// Assumes: sys and high ticks run at pclk, subsidiary tick every 10
// Notes:   counts get a little slack for tick and sync latency
`timescale 1ns/1ns
`default_nettype none
`include "ctm_regs.vh"
module compact_timer_10bit_tb;
  // ====
  // bench signals
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        sub = 1'b0;
  wire  [31:0] prdata;
  wire         pready, pslverr, pin, pinb, oen_n, fa, fp;
  logic [31:0] q;
  logic        e, x;
  int          n_mismatch = 0, total_checks = 0, v, w;
  int          dv [8] = '{4, 1, 16, 64, 10, 10, 0, 0};
  logic [7:0]  pc [6] = '{8'ha8, 8'ha8, 8'h88, 8'h98, 8'haa, 8'hac};
  int          pa [6] = '{32, 200, 32, 32, 256, 32};
  int          ph [6] = '{128, 512, 0, 512, 256, 384};
  always #50 pclk = ~pclk;
  always begin
    repeat (5) @(posedge pclk);
    sub <= ~sub;
  end
  ctm_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .subsidiary_clock(sub), .timer_output_pin(pin),
    .timer_output_pin_inverted(pinb), .timer_output_enable_n(oen_n),
    .compare_a_flag(fa), .compare_p_flag(fp));
  // ====
  // tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] xp);
    total_checks++;
    if (g !== xp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, g, xp);
    end
  endtask
  // one idle edge after each transfer keeps strobes single-driven
  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    if (n >= 20) n_mismatch++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic cnt(output int c);
    bus(0, `CTM_OFS_CNT_HI, 8'h00);
    c = q[1:0] * 256;
    bus(0, `CTM_OFS_CNT_LO, 8'h00);
    c += q[7:0];
  endtask
  task automatic run(input logic [7:0] c1, input logic [9:0] a,
                     input logic [7:0] c0, input int cyc);
    bus(1, `CTM_OFS_CTRL0, 8'h00);
    bus(1, `CTM_OFS_FLAGS, 8'h03);
    bus(1, `CTM_OFS_CTRL1, c1);
    bus(1, `CTM_OFS_CMP_LO, a[7:0]);
    bus(1, `CTM_OFS_CMP_HI, {6'h0, a[9:8]});
    bus(1, `CTM_OFS_CTRL0, c0);
    repeat (cyc) @(posedge pclk);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #(100 * 40000);
    n_mismatch++;
    results();
  end
  // ====
  // main sequence
  initial begin
    v = $urandom(32'hb57e212f);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    bus(0, `CTM_OFS_CTRL0, 8'h00);
    chk(q, {24'h0, `CTM_CTRL0_RST});
    bus(0, `CTM_OFS_CTRL1, 8'h00);
    chk(q, {24'h0, `CTM_CTRL1_RST});
    bus(0, 12'h01c, 8'h00);
    chk({q[30:0], e}, 32'h1);
    w = $urandom & 32'h3f;
    bus(1, `CTM_OFS_CTRL1, w[7:0]);
    bus(0, `CTM_OFS_CTRL1, 8'h00);
    chk(q, w);
    bus(1, `CTM_OFS_CTRL1, 8'h00);
    v = $urandom & 32'h3ff;
    bus(1, `CTM_OFS_CMP_LO, v[7:0]);
    bus(1, `CTM_OFS_CMP_HI, {6'h0, v[9:8]});
    bus(1, `CTM_OFS_CMP_LO, ~v[7:0]);
    bus(0, `CTM_OFS_CMP_HI, 8'h00);
    w = q[1:0] * 256;
    bus(0, `CTM_OFS_CMP_LO, 8'h00);
    chk(w + q[7:0], v);
    $display("test registers done");
    for (int k = 0; k < 8; k++) begin
      bus(1, `CTM_OFS_CTRL0, {1'b0, k[2:0], 1'b1, 3'h0});
      repeat (320) @(posedge pclk);
      bus(1, `CTM_OFS_CTRL0, {1'b0, k[2:0], 1'b0, 3'h0});
      cnt(v);
      cnt(w);
      chk(v, w);
      w = (k > 5) ? 0 : 323 / dv[k];
      chk((v - w) inside {[-4:4]}, 1);
    end
    bus(1, `CTM_OFS_CTRL0, 8'h18);
    bus(1, `CTM_OFS_CTRL0, 8'h98);
    cnt(v);
    repeat (50) @(posedge pclk);
    cnt(w);
    chk(w, v);
    bus(1, `CTM_OFS_CTRL0, 8'h18);
    repeat (40) @(posedge pclk);
    cnt(w);
    chk((w - v) inside {[40:50]}, 1);
    $display("test counting done");
    run(8'h00, 10'h3ff, 8'h19, 300);
    chk({fa, fp}, 2'b01);
    cnt(v);
    chk(v < 128, 1);
    run(8'h01, 10'd300, 8'h19, 700);
    cnt(v);
    chk({fa, fp, v <= 300}, 3'b101);
    run(8'h01, 10'd0, 8'h19, 1100);
    chk({fa, fp}, 2'b00);
    cnt(v);
    chk((v - 78) inside {[-4:4]}, 1);
    $display("test clearing done");
    for (int i = 0; i < 8; i++) begin
      w = $urandom & 1;
      run({2'h0, i[1:0], i[2], w[0], 2'h0}, 10'd20, 8'h19, 60);
      x = (i[1] ? (i[0] ? ~i[2] : 1'b1) : (i[0] ? 1'b0 : i[2])) ^ w[0];
      chk({pin, pinb, oen_n}, {x, ~x, 1'b0});
    end
    run(8'hc0, 10'd20, 8'h19, 10);
    chk(oen_n, 1'b1);
    $display("test compare done");
    for (int i = 0; i < 6; i++) begin
      w = $urandom & 1;
      run(pc[i] | {7'h0, w[0]}, pa[i][9:0], 8'h19, 64);
      v = 0;
      repeat (512) begin
        @(posedge pclk);
        v += pin;
      end
      chk((v - ph[i]) inside {[-4:4]}, 1);
    end
    $display("test pwm done");
    results();
  end
endmodule
`default_nettype wire
